/* File: monitor_irq_pkg.sv */
package monitor_irq_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          PULSE_MS      = 20;
  localparam int          PULSE_CYCLES  = CLK_HZ / 1000 * PULSE_MS;
  localparam int          RAM_DEPTH     = 32;
  localparam logic [7:0]  CFG_RESET     = 8'h08;
  localparam logic [7:0]  NMASK2_RESET  = 8'h40;
  localparam logic [7:0]  HYST_THERMO   = 8'h7F;
  localparam int          CFG_START     = 0;
  localparam int          CFG_SMI_EN    = 1;
  localparam int          CFG_NMI_EN    = 2;
  localparam int          CFG_INT_CLR   = 3;
  localparam int          CFG_RST_PULSE = 4;
  localparam int          CFG_NMI_SEL   = 5;
  localparam int          CFG_PWR_HOLD  = 6;
  localparam int          BIT_HI        = 7;
  localparam logic [6:0]  IDX_CFG       = 7'h40;
  localparam logic [6:0]  IDX_STAT1     = 7'h41;
  localparam logic [6:0]  IDX_STAT2     = 7'h42;
  localparam logic [6:0]  IDX_SMASK1    = 7'h43;
  localparam logic [6:0]  IDX_SMASK2    = 7'h44;
  localparam logic [6:0]  IDX_NMASK1    = 7'h45;
  localparam logic [6:0]  IDX_NMASK2    = 7'h46;
  localparam int          ST2_TEMP      = 0;
  localparam int          ST2_ALERT     = 1;
  localparam int          ST2_INTRUDE   = 2;
  localparam int          ST2_CHAIN     = 3;
  localparam int          ST2_OVF       = 4;

  typedef enum logic [1:0] {
    TEMP_ARMED = 2'b00,
    TEMP_HOT   = 2'b01,
    TEMP_COLD  = 2'b10
  } temp_state_type;

  // Host data-port access already decoded by the bus front end.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] idx;
    logic [7:0] wdata;
  } host_req_type;

  // One completed monitoring-loop measurement.
  typedef struct packed {
    logic       valid;
    logic [7:0] temp;
    logic [7:0] overtemp_setpoint;
    logic [7:0] hysteresis_setpoint;
    logic [7:0] limit_flags1;
    logic [2:0] limit_flags2;
  } measure_type;
endpackage

/* File: monitor_interrupt_and_control.sv */
module monitor_interrupt_and_control #(
  parameter int PULSE_LEN = monitor_irq_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Host register access and selftest port
  input  wire monitor_irq_pkg::host_req_type host_req_i,
  input  wire logic                          selftest_code_wr_i,
  input  wire logic [7:0]                    selftest_code_i,
  output logic [7:0]                         host_rdata_o,
  output logic [6:0]                         next_idx_o,
  // Monitoring loop
  input  wire monitor_irq_pkg::measure_type  measure_i,
  output logic                               loop_halt_o,
  // External interrupt pins
  input  wire logic                          board_temp_alert_in_n_i,
  input  wire logic                          chassis_intrusion_i,
  input  wire logic                          chained_mgmt_irq_in_n_i,
  // Interrupt outputs
  output logic                               host_irq_n_o,
  output logic                               sys_mgmt_irq_out_n_o,
  input  wire logic                          sys_mgmt_irq_pin_i,
  // Open-drain controls, enable low while driving
  output logic                               intrusion_clr_oe_n_o,
  output logic                               power_hold_oe_n_o,
  output logic                               reset_oe_n_o,
  // Tree test
  input  wire logic                          tree_in_i,
  output logic                               tree_float_o,
  output logic                               tree_test_out_o
);
  import monitor_irq_pkg::*;

  logic [7:0]     cfg;
  logic [7:0]     stat1;
  logic [7:0]     stat2;
  logic [7:0]     smask1;
  logic [7:0]     smask2;
  logic [7:0]     nmask1;
  logic [7:0]     nmask2;
  logic [7:0]     ram [RAM_DEPTH];
  logic [5:0]     wr_ptr;
  logic [4:0]     rd_ptr;
  logic [1:0]     alert_sync;
  logic [1:0]     intr_sync;
  logic [1:0]     chain_sync;
  logic [1:0]     mgmt_sync;
  logic [1:0]     tree_sync;
  logic [31:0]    intr_cnt;
  logic [31:0]    rst_cnt;
  logic           cfg_written;
  logic           ram_ovf;
  temp_state_type temp_state;
  logic           temp_event;
  logic           host_any;
  logic           mgmt_any;
  logic           upd;
  logic           rd1;
  logic           rd2;
  logic           temp_over;
  logic           temp_under;
  logic [7:0]     stat2_set;

  // Decode used only for the index advance; the clear-on-read path decodes rd1 and rd2 itself.
  function automatic logic is_pair_low(input logic [6:0] idx);
    return idx == IDX_STAT1 || idx == IDX_SMASK1 || idx == IDX_NMASK1;
  endfunction

  assign upd = measure_i.valid && !cfg[CFG_INT_CLR];
  assign rd1 = host_req_i.rd && host_req_i.idx == IDX_STAT1;
  assign rd2 = host_req_i.rd && host_req_i.idx == IDX_STAT2;

  // Both readings are two's complement with one degree per LSB, so compare signed.
  assign temp_over  = $signed(measure_i.temp) > $signed(measure_i.overtemp_setpoint);
  assign temp_under = $signed(measure_i.temp) < $signed(measure_i.hysteresis_setpoint);

  // Pin synchronisers: first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    alert_sync <= {alert_sync[0], board_temp_alert_in_n_i};
    intr_sync  <= {intr_sync[0], chassis_intrusion_i};
    chain_sync <= {chain_sync[0], chained_mgmt_irq_in_n_i};
    mgmt_sync  <= {mgmt_sync[0], sys_mgmt_irq_pin_i};
    tree_sync  <= {tree_sync[0], tree_in_i};
  end

  // Temperature comparator. Hot means the setpoint was crossed, and the next
  // event then waits for the reading to fall under the hysteresis setpoint.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_state <= TEMP_ARMED;
    end else if (upd) begin
      if (measure_i.hysteresis_setpoint == HYST_THERMO) begin
        temp_state <= TEMP_ARMED;
      end else begin
        case (temp_state)
          TEMP_ARMED: begin
            if (temp_over) begin
              temp_state <= TEMP_HOT;
            end
          end
          TEMP_HOT: begin
            if (temp_under) begin
              temp_state <= TEMP_COLD;
            end
          end
          TEMP_COLD: begin
            if (temp_over) begin
              temp_state <= TEMP_HOT;
            end
          end
          default: temp_state <= TEMP_ARMED;
        endcase
      end
    end
  end

  // Event for this measurement: thermostat mode re-fires every cycle while hot,
  // and stops on the first cycle at or below the setpoint.
  always_comb begin
    temp_event = 1'b0;
    if (measure_i.hysteresis_setpoint == HYST_THERMO) begin
      temp_event = temp_over;
    end else if (temp_state == TEMP_ARMED || temp_state == TEMP_COLD) begin
      temp_event = temp_over;
    end else begin
      temp_event = temp_under;
    end
  end

  // Status registers: clear on read, but a same-cycle update wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat1 <= 8'h00;
    end else begin
      stat1 <= (rd1 ? 8'h00 : stat1) | (upd ? measure_i.limit_flags1 : 8'h00);
    end
  end

  // Events of one measurement; the top three bits carry the second limit group.
  assign stat2_set = {measure_i.limit_flags2, ram_ovf, !chain_sync[1], intr_sync[1],
                      !alert_sync[1], temp_event};

  // Status two clears on its own read. The host acknowledges the temperature
  // event through status one, so that read drops the temperature bit as well.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat2 <= 8'h00;
    end else if (rd2) begin
      stat2 <= upd ? stat2_set : 8'h00;
    end else if (rd1) begin
      stat2 <= (stat2 & ~(8'h01 << ST2_TEMP)) | (upd ? stat2_set : 8'h00);
    end else begin
      stat2 <= stat2 | (upd ? stat2_set : 8'h00);
    end
  end

  // Configuration and mask registers. A host write wins over the self-clear of
  // the reset pulse bit, so software can always re-arm the pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg         <= CFG_RESET;
      cfg_written <= 1'b0;
    end else begin
      if (host_req_i.wr && host_req_i.idx == IDX_CFG) begin
        cfg         <= host_req_i.wdata;
        cfg_written <= 1'b1;
      end else if (rst_cnt == 32'd1) begin
        cfg[CFG_RST_PULSE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smask1 <= 8'h00;
      smask2 <= 8'h00;
      nmask1 <= 8'h00;
      nmask2 <= NMASK2_RESET;
    end else begin
      if (host_req_i.wr && host_req_i.idx == IDX_SMASK1) begin
        smask1 <= host_req_i.wdata;
      end
      if (host_req_i.wr && host_req_i.idx == IDX_SMASK2) begin
        smask2 <= host_req_i.wdata;
      end
      if (host_req_i.wr && host_req_i.idx == IDX_NMASK1) begin
        nmask1 <= host_req_i.wdata;
      end
      // The top host mask bit is a command, not a mask, and clears itself.
      if (host_req_i.wr && host_req_i.idx == IDX_NMASK2) begin
        nmask2 <= host_req_i.wdata;
      end else if (intr_cnt == 32'd1) begin
        nmask2[BIT_HI] <= 1'b0;
      end
    end
  end

  // Chassis intrusion clear pulse. The command bit drops on the last count,
  // so the counter sees it low when it reaches zero and cannot re-trigger.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intr_cnt <= 32'd0;
    end else if (intr_cnt != 32'd0) begin
      intr_cnt <= intr_cnt - 32'd1;
    end else if (nmask2[BIT_HI]) begin
      intr_cnt <= 32'(PULSE_LEN);
    end
  end

  // Reset output pulse; the count is only started when the output is enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt <= 32'd0;
    end else if (rst_cnt != 32'd0) begin
      rst_cnt <= rst_cnt - 32'd1;
    end else if (cfg[CFG_RST_PULSE] && smask2[BIT_HI]) begin
      rst_cnt <= 32'(PULSE_LEN);
    end
  end

  // Selftest code RAM; the write pointer sticks one past the end.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr  <= 6'h00;
      ram_ovf <= 1'b0;
    end else begin
      if (upd) begin
        ram_ovf <= 1'b0;
      end
      if (selftest_code_wr_i) begin
        if (wr_ptr < 6'(RAM_DEPTH)) begin
          wr_ptr <= wr_ptr + 6'h01;
        end else begin
          ram_ovf <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (selftest_code_wr_i && wr_ptr < 6'(RAM_DEPTH)) begin
      ram[wr_ptr[4:0]] <= selftest_code_i;
    end
  end

  // The read pointer is separate from the write pointer and wraps after the last word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ptr <= 5'h00;
    end else if (host_req_i.rd && host_req_i.idx < 7'(RAM_DEPTH)) begin
      rd_ptr <= rd_ptr + 5'h01;
    end
  end

  // Read data and index advance.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_rdata_o <= 8'h00;
      next_idx_o   <= 7'h00;
    end else if (host_req_i.rd || host_req_i.wr) begin
      next_idx_o <= is_pair_low(host_req_i.idx) ? host_req_i.idx + 7'h01
                                                : host_req_i.idx;
      // Unmapped indexes read as zero.
      if (host_req_i.idx < 7'(RAM_DEPTH)) begin
        host_rdata_o <= ram[rd_ptr];
      end else if (host_req_i.idx == IDX_CFG) begin
        host_rdata_o <= cfg;
      end else if (host_req_i.idx == IDX_STAT1) begin
        host_rdata_o <= stat1;
      end else if (host_req_i.idx == IDX_STAT2) begin
        host_rdata_o <= stat2;
      end else if (host_req_i.idx == IDX_SMASK1) begin
        host_rdata_o <= smask1;
      end else if (host_req_i.idx == IDX_SMASK2) begin
        host_rdata_o <= smask2;
      end else if (host_req_i.idx == IDX_NMASK1) begin
        host_rdata_o <= nmask1;
      end else if (host_req_i.idx == IDX_NMASK2) begin
        host_rdata_o <= nmask2;
      end else begin
        host_rdata_o <= 8'h00;
      end
    end
  end

  // The top bit of status two never reaches either line: its host mask bit is
  // the intrusion clear command, and both lines treat it alike.
  assign host_any = |(stat1 & ~nmask1) || |(stat2 & ~nmask2 & 8'h7F);
  assign mgmt_any = |(stat1 & ~smask1) || |(stat2 & ~smask2 & 8'h7F);

  // Interrupt outputs. The host line mode bit selects a held level or a
  // single-cycle strobe on a new assertion.
  logic host_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_irq_n_o         <= 1'b1;
      sys_mgmt_irq_out_n_o <= 1'b1;
      host_prev            <= 1'b0;
      loop_halt_o          <= 1'b1;
    end else begin
      host_prev   <= host_any;
      loop_halt_o <= cfg[CFG_INT_CLR];
      if (cfg[CFG_INT_CLR]) begin
        host_irq_n_o         <= 1'b1;
        sys_mgmt_irq_out_n_o <= 1'b1;
      end else begin
        host_irq_n_o <= !(cfg[CFG_NMI_EN] && host_any
                          && (!cfg[CFG_NMI_SEL] || !host_prev));
        sys_mgmt_irq_out_n_o <= !(cfg[CFG_SMI_EN] && mgmt_any);
      end
    end
  end

  // Open-drain drivers and tree test. The float request is honoured only before
  // the first configuration write; any configuration write releases the pins for good.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intrusion_clr_oe_n_o <= 1'b1;
      power_hold_oe_n_o    <= 1'b1;
      reset_oe_n_o         <= 1'b1;
      tree_float_o         <= 1'b0;
      tree_test_out_o      <= 1'b0;
    end else begin
      intrusion_clr_oe_n_o <= intr_cnt == 32'd0;
      power_hold_oe_n_o    <= !cfg[CFG_PWR_HOLD];
      reset_oe_n_o         <= rst_cnt == 32'd0;
      if (!cfg_written && !cfg[CFG_START] && cfg[CFG_INT_CLR] && !mgmt_sync[1]) begin
        tree_float_o <= 1'b1;
      end else if (cfg_written) begin
        tree_float_o <= 1'b0;
      end
      tree_test_out_o <= !tree_sync[1];
    end
  end
endmodule

/* File: monitor_checker.sv */
module monitor_checker
  import monitor_irq_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  // Clock, reset and requests
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire host_req_type host_req_i,
  input wire measure_type  measure_i,
  input wire logic         tree_in_i,
  // Observed outputs
  input wire logic [7:0]   host_rdata_o,
  input wire logic [6:0]   next_idx_o,
  input wire logic         loop_halt_o,
  input wire logic         host_irq_n_o,
  input wire logic         sys_mgmt_irq_out_n_o,
  input wire logic         intrusion_clr_oe_n_o,
  input wire logic         power_hold_oe_n_o,
  input wire logic         reset_oe_n_o,
  input wire logic         tree_test_out_o
);
  logic [31:0] low_cnt;
  logic        cfg_wr;
  assign cfg_wr = host_req_i.wr && host_req_i.idx == IDX_CFG;
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_oe_n_o) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_halt_follows_cfg: assert property (
    cfg_wr |-> ##2 loop_halt_o == $past(host_req_i.wdata[CFG_INT_CLR], 2))
    else $error("loop halt does not follow the clear bit");
  a_halt_quiets_irq: assert property (
    loop_halt_o [*2] |-> host_irq_n_o && sys_mgmt_irq_out_n_o)
    else $error("interrupt output active while halted");
  a_stat_idx_adv: assert property (
    host_req_i.rd && host_req_i.idx == IDX_STAT1 |=> next_idx_o == IDX_STAT2)
    else $error("index did not advance after status read");
  a_read_clears: assert property (
    (host_req_i.rd && host_req_i.idx == IDX_STAT2 && !measure_i.valid) [*2]
      |=> host_rdata_o == 8'h00)
    else $error("second status read not cleared");
  a_unmapped_zero: assert property (
    host_req_i.rd && host_req_i.idx == 7'h7F |=> host_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_power_hold: assert property (
    cfg_wr && host_req_i.wdata[CFG_PWR_HOLD] |-> ##[1:2] !power_hold_oe_n_o)
    else $error("power hold not driven");
  a_reset_len: assert property (
    $rose(reset_oe_n_o) |-> low_cnt >= PULSE_LEN)
    else $error("reset pulse too short");
  a_intrusion_len: assert property (
    $fell(intrusion_clr_oe_n_o) |-> !intrusion_clr_oe_n_o [*8])
    else $error("intrusion clear pulse too short");
  a_tree_invert: assert property (
    $stable(tree_in_i) [*6] |-> tree_test_out_o == !tree_in_i)
    else $error("tree output not inverted input");
  c_host_irq: cover property (!host_irq_n_o);
  c_reset_pulse: cover property ($fell(reset_oe_n_o));
  c_intrusion: cover property ($fell(intrusion_clr_oe_n_o));
endmodule

bind monitor_interrupt_and_control monitor_checker #(.PULSE_LEN(PULSE_LEN)) monitor_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .host_req_i(host_req_i), .measure_i(measure_i),
  .tree_in_i(tree_in_i), .host_rdata_o(host_rdata_o), .next_idx_o(next_idx_o),
  .loop_halt_o(loop_halt_o), .host_irq_n_o(host_irq_n_o),
  .sys_mgmt_irq_out_n_o(sys_mgmt_irq_out_n_o), .intrusion_clr_oe_n_o(intrusion_clr_oe_n_o),
  .power_hold_oe_n_o(power_hold_oe_n_o), .reset_oe_n_o(reset_oe_n_o),
  .tree_test_out_o(tree_test_out_o));

/* File: host_model.sv */
module host_model
  import monitor_irq_pkg::*;
(
  // Clock and data-port request
  input  wire logic   clk_i,
  output host_req_type req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // The request is held from one falling edge past the rising edge that takes it.
  task automatic acc(input logic r, input logic w, input logic [6:0] i, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{rd: r, wr: w, idx: i, wdata: d};
    @(posedge clk_i);
  endtask
  task automatic idle();
    @(negedge clk_i);
    req_o = '0;
  endtask
endmodule

/* File: tb_monitor_interrupt_and_control.sv */
module tb_monitor_interrupt_and_control
  import monitor_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PL = 16;
  logic clk = 0, rst = 1, st_wr = 0, alert_n = 1, intr = 0, chain_n = 1, tree = 1, smi_low = 0;
  logic [7:0] st_d = 8'h00, f1, rdata;
  logic [2:0] f2;
  logic [6:0] nidx;
  logic halt, hirq_n, mirq_n, ic_oe_n, ph_oe_n, rs_oe_n, tfloat, tout, taken = 0;
  logic [15:0] expq[$], e;
  measure_type  meas_s = '0;
  host_req_type req;
  wire logic    mpin = mirq_n & ~smi_low;
  int n_errors = 0, total_checks = 0, n;
  host_model host_model_inst (.clk_i(clk), .req_o(req));
  monitor_interrupt_and_control #(.PULSE_LEN(PL)) monitor_interrupt_and_control_inst (
    .clk_i(clk), .rst_i(rst), .host_req_i(req), .selftest_code_wr_i(st_wr),
    .selftest_code_i(st_d), .host_rdata_o(rdata), .next_idx_o(nidx), .measure_i(meas_s),
    .loop_halt_o(halt), .board_temp_alert_in_n_i(alert_n), .chassis_intrusion_i(intr),
    .chained_mgmt_irq_in_n_i(chain_n), .host_irq_n_o(hirq_n), .sys_mgmt_irq_out_n_o(mirq_n),
    .sys_mgmt_irq_pin_i(mpin), .intrusion_clr_oe_n_o(ic_oe_n), .power_hold_oe_n_o(ph_oe_n),
    .reset_oe_n_o(rs_oe_n), .tree_in_i(tree), .tree_float_o(tfloat), .tree_test_out_o(tout));
  always #10 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Expected read data carries a care mask in its upper byte.
  task automatic rd(input logic [6:0] i, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    expq.push_back({m, x});
    host_model_inst.acc(1'b1, 1'b0, i, 8'h00);
    host_model_inst.idle();
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    host_model_inst.acc(1'b0, 1'b1, i, d);
    host_model_inst.idle();
  endtask
  // A measurement is held valid for one cycle, then three idle cycles let status settle.
  task automatic meas(input logic [7:0] t, o, h, fa, input logic [2:0] fb);
    @(negedge clk);
    meas_s = '{1'b1, t, o, h, fa, fb};
    @(negedge clk);
    meas_s.valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic cnt(input bit s);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (!(s ? ic_oe_n : rs_oe_n)) n++;
    end
  endtask
  task automatic do_reset();
    rst = 1;
    repeat (16) @(negedge clk);
    rst = 0;
  endtask
  always @(posedge clk) taken <= req.rd;
  always @(negedge clk) begin
    if (taken) begin
      e = expq.pop_front();
      chk(rdata & e[15:8], e[7:0]);
    end
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h640eb092));
    do_reset();
    smi_low = 1;
    repeat (6) @(negedge clk);
    chk(tfloat, 1);
    for (int i = 0; i < 2; i++) begin
      tree = i[0];
      repeat (6) @(negedge clk);
      chk(tout, !tree);
    end
    smi_low = 0;
    do_reset();
    rd(IDX_CFG, CFG_RESET);
    rd(IDX_NMASK2, NMASK2_RESET);
    chk(halt, 1);
    meas(8'h05, 8'hF0, 8'hEC, 8'hFF, 3'h0);
    rd(IDX_STAT1, 8'h00);
    wr(IDX_CFG, 8'h06);
    @(negedge clk);
    chk(halt, 0);
    // Signed limits: 05h is above F0h only when read as two's complement.
    meas(8'h05, 8'hF0, 8'hEC, 8'h00, 3'h0);
    chk(hirq_n, 0);
    chk(mirq_n, 0);
    expq.push_back(16'hFF01);
    expq.push_back(16'hFF00);
    host_model_inst.acc(1'b1, 1'b0, IDX_STAT2, 8'h00);
    host_model_inst.acc(1'b1, 1'b0, IDX_STAT2, 8'h00);
    host_model_inst.idle();
    rd(IDX_STAT1, 8'h00);
    chk(nidx, IDX_STAT2);
    repeat (2) @(negedge clk);
    chk(hirq_n, 1);
    meas(8'h05, 8'hF0, 8'hEC, 8'h00, 3'h0);
    rd(IDX_STAT2, 8'h00);
    meas(8'hE7, 8'hF0, 8'hEC, 8'h00, 3'h0);
    rd(IDX_STAT2, 8'h01);
    // A status one read drops the temperature event; the next measurement sets it again.
    for (int i = 0; i < 3; i++) begin
      meas(8'h05, 8'hF0, HYST_THERMO, 8'h00, 3'h0);
      if (i == 1) rd(IDX_STAT1, 8'h00);
      rd(IDX_STAT2, (i == 1) ? 8'h00 : 8'h01);
    end
    for (int i = 0; i < 3; i++) begin
      meas(8'hE7, 8'hF0, HYST_THERMO, 8'h00, 3'h0);
      rd(IDX_STAT2, 8'h00, (i < 2) ? 8'h00 : 8'hFF);
    end
    for (int i = 0; i < 3; i++) begin
      alert_n = (i != 0);
      intr = (i == 1);
      chain_n = (i != 2);
      repeat (3) @(negedge clk);
      meas(8'hE7, 8'hF0, HYST_THERMO, 8'h00, 3'h0);
      {alert_n, intr, chain_n} = 3'b101;
      repeat (3) @(negedge clk);
      rd(IDX_STAT2, 8'h02 << i);
    end
    f1 = 8'($urandom);
    f2 = 3'($urandom);
    meas(8'hE7, 8'hF0, HYST_THERMO, f1, f2);
    rd(IDX_STAT1, f1);
    rd(IDX_STAT2, {f2, 5'h00});
    wr(IDX_SMASK1, 8'hFF);
    meas(8'hE7, 8'hF0, HYST_THERMO, 8'h01, 3'h0);
    chk(hirq_n, 0);
    chk(mirq_n, 1);
    wr(IDX_CFG, 8'h02);
    repeat (2) @(negedge clk);
    chk(hirq_n, 1);
    rd(IDX_STAT1, 8'h01);
    wr(IDX_SMASK1, 8'h00);
    wr(IDX_CFG, 8'h56);
    cnt(0);
    chk(n, 0);
    chk(ph_oe_n, 0);
    wr(IDX_CFG, 8'h46);
    wr(IDX_SMASK2, 8'h80);
    wr(IDX_CFG, 8'h56);
    cnt(0);
    chk(n >= PL, 1);
    rd(IDX_CFG, 8'h46);
    wr(IDX_NMASK2, 8'hC0);
    cnt(1);
    chk(n >= PL, 1);
    rd(IDX_NMASK2, 8'h40);
    for (int i = 0; i < 33; i++) begin
      @(negedge clk);
      st_wr = 1;
      st_d = 8'hA5 ^ i[7:0];
    end
    @(negedge clk);
    st_wr = 0;
    meas(8'hE7, 8'hF0, HYST_THERMO, 8'h00, 3'h0);
    rd(IDX_STAT2, 8'h10, 8'h10);
    for (int i = 0; i < 32; i++) rd(7'h00, 8'hA5 ^ i[7:0]);
    rd(7'h7F, 8'h00);
    @(negedge clk);
    chk(8'(expq.size()), 8'h00);
    close_out();
  end
endmodule
